// ===== rtl/wdt_watchdog.sv
// watchdog timeout chain with reset pin driver and AHB-Lite register slave
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module wdt_watchdog #(
    parameter int ADDR_W = 18
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    input wire logic [7:0] reset_vector_low,
    input wire logic internal_reset,
    input wire logic vector_fetch,
    input wire logic stop_exec,
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic monitor_mode,
    input wire logic break_active,
    input wire logic irq_test_high_voltage,
    input wire logic rst_test_high_voltage,
    output logic reset_pin_out,
    output logic reset_pin_oe_n,
    output logic watchdog_reset_req
);
    initial begin
        if (ADDR_W < 18 || ADDR_W > 32) begin
            $error("wdt_watchdog: ADDR_W must lie between 18 and 32");
        end
    end

    // pin level inputs
    logic irq_tst;
    logic rst_tst;

    wdt_pin_sync #(.RESET_VALUE(1'b0)) u_irq_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .pin(irq_test_high_voltage),
        .level(irq_tst)
    );

    wdt_pin_sync #(.RESET_VALUE(1'b0)) u_rst_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .pin(rst_test_high_voltage),
        .level(rst_tst)
    );

    // bus address phase capture
    logic wr_pend_reg;
    logic [15:0] wr_idx_reg;
    logic [31:0] hrdata_reg;
    logic [2:0] cfg_reg;
    logic cfg_lock_reg;
    logic [1:0] cause_reg;
    logic [11:0] presc_reg;
    logic [5:0] cnt_reg;

    wire logic addr_phase = hsel && hready && (htrans == wdt_pkg::HTRANS_NONSEQ);
    wire logic word_ok = (hsize == wdt_pkg::HSIZE_WORD) && (haddr[1:0] == 2'b00);
    wire logic [ADDR_W-3:0] addr_idx = haddr[ADDR_W-1:2];
    wire logic idx_fits = (addr_idx[ADDR_W-3:0] >> 16) == '0;
    wire logic [15:0] cur_idx = addr_idx[15:0];
    wire logic wr_take = addr_phase && hwrite && word_ok && idx_fits;
    wire logic rd_take = addr_phase && !hwrite;

    wire logic wr_service = wr_pend_reg && (wr_idx_reg == wdt_pkg::SERVICE_IDX);
    wire logic wr_cfg = wr_pend_reg && (wr_idx_reg == wdt_pkg::CFG_IDX);
    wire logic wr_cause = wr_pend_reg && (wr_idx_reg == wdt_pkg::CAUSE_IDX);

    // monitor and break disable conditions
    logic mon_prev_reg;
    logic mon_tst_entry_reg;
    logic blank_disable_reg;
    wire logic mon_rise = monitor_mode && !mon_prev_reg;
    wire logic mon_tst_hold = monitor_mode && mon_tst_entry_reg && (irq_tst || rst_tst);
    wire logic brk_hold = break_active && rst_tst;
    wire logic cfg_disable = cfg_reg[wdt_pkg::CFG_DISABLE_BIT];
    wire logic disabled = cfg_disable || mon_tst_hold || blank_disable_reg || brk_hold;
    wire logic rate_short = cfg_reg[wdt_pkg::CFG_RATE_BIT];
    wire logic stop_enabled = cfg_reg[wdt_pkg::CFG_STOP_EN_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mon_prev_reg <= 1'b0;
            mon_tst_entry_reg <= 1'b0;
            blank_disable_reg <= 1'b0;
        end else begin
            mon_prev_reg <= monitor_mode;
            if (mon_rise) begin
                mon_tst_entry_reg <= irq_tst;
            end
            if (mon_rise && !irq_tst) begin
                blank_disable_reg <= 1'b1;
            end
        end
    end

    // power-up prescaler clear
    logic [12:0] por_cnt_reg;
    logic por_done_reg;
    wire logic por_clear = !por_done_reg && (por_cnt_reg == wdt_pkg::POR_CLEAR_LAST);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            por_cnt_reg <= 13'h0000;
            por_done_reg <= 1'b0;
        end else if (!por_done_reg) begin
            por_cnt_reg <= por_cnt_reg + 13'h0001;
            por_done_reg <= por_clear;
        end
    end

    // reset sequencer
    wdt_pkg::wdt_seq_t seq_reg;
    wdt_pkg::wdt_seq_t seq_next;
    logic [4:0] hold_cnt_reg;
    logic overflow;
    wire logic illegal_stop = stop_exec && !stop_enabled;
    wire logic stop_ok = stop_exec && stop_enabled;
    wire logic trigger = (overflow || illegal_stop) && (seq_reg == wdt_pkg::WDT_SEQ_IDLE);
    wire logic hold_last = hold_cnt_reg == wdt_pkg::RESET_HOLD_LAST;
    wire logic seq_done = seq_reg == wdt_pkg::WDT_SEQ_DONE;
    wire logic cfg_clear = internal_reset || seq_done;

    always_comb begin
        seq_next = seq_reg;
        case (seq_reg)
            wdt_pkg::WDT_SEQ_IDLE: begin
                if (trigger) begin
                    seq_next = wdt_pkg::WDT_SEQ_HOLD;
                end
            end
            wdt_pkg::WDT_SEQ_HOLD: begin
                if (hold_last) begin
                    seq_next = wdt_pkg::WDT_SEQ_DONE;
                end
            end
            default: begin
                seq_next = wdt_pkg::WDT_SEQ_IDLE;
            end
        endcase
    end

    logic pin_out_reg;
    logic pin_oe_n_reg;
    logic req_reg;
    wire logic hold_next = (seq_next == wdt_pkg::WDT_SEQ_HOLD);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_reg <= wdt_pkg::WDT_SEQ_IDLE;
            hold_cnt_reg <= 5'h00;
            pin_out_reg <= 1'b1;
            pin_oe_n_reg <= 1'b1;
            req_reg <= 1'b0;
        end else begin
            seq_reg <= seq_next;
            hold_cnt_reg <= (seq_reg == wdt_pkg::WDT_SEQ_HOLD) ? hold_cnt_reg + 5'h01 : 5'h00;
            pin_out_reg <= !hold_next;
            pin_oe_n_reg <= !hold_next;
            req_reg <= hold_next;
        end
    end

    // timeout chain; wait mode does not gate it
    wire logic clear_all = disabled || internal_reset || trigger;
    wire logic presc_clear = por_clear || vector_fetch || stop_ok;
    wire logic freeze = stop_mode;
    wire logic tap_adv = rate_short ? (presc_reg[6:0] == wdt_pkg::SHORT_TAP_V)
                                    : (presc_reg == wdt_pkg::LONG_TAP_V);
    wire logic term_hit = rate_short ? (presc_reg[6:0] == wdt_pkg::SHORT_TERM_V)
                                     : (presc_reg == wdt_pkg::LONG_TERM_V);
    assign overflow = !disabled && !freeze && (cnt_reg == 6'(wdt_pkg::CNT_LAST)) && term_hit;
    wire logic wait_seen = wait_mode;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_reg <= 12'h000;
            cnt_reg <= 6'h00;
        end else if (clear_all) begin
            presc_reg <= 12'h000;
            cnt_reg <= 6'h00;
        end else if (wr_service) begin
            presc_reg <= presc_reg & ~wdt_pkg::SERVICE_CLR_MASK;
            cnt_reg <= 6'h00;
        end else if (presc_clear) begin
            presc_reg <= 12'h000;
        end else if (!freeze || wait_seen) begin
            if (!freeze) begin
                presc_reg <= presc_reg + 12'h001;
                if (tap_adv) begin
                    cnt_reg <= cnt_reg + 6'h01;
                end
            end
        end
    end

    // configuration and reset cause
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_reg <= wdt_pkg::CFG_RESET;
            cfg_lock_reg <= 1'b0;
        end else if (cfg_clear) begin
            cfg_reg <= wdt_pkg::CFG_RESET;
            cfg_lock_reg <= 1'b0;
        end else if (wr_cfg && !cfg_lock_reg) begin
            cfg_reg <= hwdata[2:0];
            cfg_lock_reg <= 1'b1;
        end
    end

    wire logic [1:0] cause_set = {illegal_stop && trigger, overflow && trigger};
    wire logic [1:0] cause_clr = wr_cause ? hwdata[1:0] : 2'b00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cause_reg <= 2'b00;
        end else begin
            cause_reg <= (cause_reg & ~cause_clr) | cause_set;
        end
    end

    // bus slave: zero wait states, always OKAY
    wire logic [31:0] status_word = {12'h000, cfg_lock_reg, disabled, cnt_reg, presc_reg};
    wire logic [31:0] rd_service = {24'h00_0000, reset_vector_low};
    wire logic [31:0] rd_cfg = {29'h0000_0000, cfg_reg};
    wire logic [31:0] rd_cause = {30'h0000_0000, cause_reg};
    logic [31:0] rd_value;

    always_comb begin
        if (!idx_fits || !word_ok) begin
            rd_value = 32'h0000_0000;
        end else if (cur_idx == wdt_pkg::SERVICE_IDX) begin
            rd_value = rd_service;
        end else if (cur_idx == wdt_pkg::CFG_IDX) begin
            rd_value = rd_cfg;
        end else if (cur_idx == wdt_pkg::CAUSE_IDX) begin
            rd_value = rd_cause;
        end else if (cur_idx == wdt_pkg::STATUS_IDX) begin
            rd_value = status_word;
        end else begin
            rd_value = 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 16'h0000;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= wr_take;
            if (wr_take) begin
                wr_idx_reg <= cur_idx;
            end
            if (rd_take) begin
                hrdata_reg <= rd_value;
            end
        end
    end

    logic hreadyout_reg;
    logic [1:0] hresp_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_reg <= 1'b1;
            hresp_reg <= wdt_pkg::HRESP_OKAY;
        end else begin
            hreadyout_reg <= 1'b1;
            hresp_reg <= wdt_pkg::HRESP_OKAY;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;
    assign reset_pin_out = pin_out_reg;
    assign reset_pin_oe_n = pin_oe_n_reg;
    assign watchdog_reset_req = req_reg;
endmodule // wdt_watchdog

// ===== rtl/wdt_pkg.sv
// constants shared by the watchdog block and its register slave
package wdt_pkg;
    // timeout chain
    localparam int PRESC_W = 12;
    localparam int CNT_W = 6;
    localparam int LONG_CYCLES = 262128;
    localparam int SHORT_CYCLES = 8176;
    localparam int LONG_TAP_SPAN = 4096;
    localparam int SHORT_TAP_SPAN = 128;
    localparam int CNT_LAST = 63;
    // prescaler value at which the final counter step ends the period
    localparam int LONG_TERM = LONG_CYCLES - CNT_LAST * LONG_TAP_SPAN - 1;
    localparam int SHORT_TERM = SHORT_CYCLES - CNT_LAST * SHORT_TAP_SPAN - 1;
    localparam logic [11:0] LONG_TERM_V = 12'(LONG_TERM);
    localparam logic [6:0] SHORT_TERM_V = 7'(SHORT_TERM);
    localparam logic [11:0] LONG_TAP_V = 12'(LONG_TAP_SPAN - 1);
    localparam logic [6:0] SHORT_TAP_V = 7'(SHORT_TAP_SPAN - 1);
    // service write clears prescaler stages 12..5, i.e. bits 11..4
    localparam logic [11:0] SERVICE_CLR_MASK = 12'h0ff0;
    // reset pin hold and power-up prescaler clear, in crystal cycles
    localparam int RESET_HOLD_CYCLES = 32;
    localparam logic [4:0] RESET_HOLD_LAST = 5'(RESET_HOLD_CYCLES - 1);
    localparam int POR_CLEAR_CYCLES = 4096;
    localparam logic [12:0] POR_CLEAR_LAST = 13'(POR_CLEAR_CYCLES - 1);
    // register indices; byte address is four times the index
    localparam logic [15:0] SERVICE_IDX = 16'hffff;
    localparam logic [15:0] CFG_IDX = 16'h0000;
    localparam logic [15:0] CAUSE_IDX = 16'h0001;
    localparam logic [15:0] STATUS_IDX = 16'h0002;
    // configuration fields
    localparam int CFG_DISABLE_BIT = 0;
    localparam int CFG_RATE_BIT = 1;
    localparam int CFG_STOP_EN_BIT = 2;
    localparam logic [2:0] CFG_RESET = 3'h0;
    // reset cause fields
    localparam int CAUSE_WDT_BIT = 0;
    localparam int CAUSE_ILLEGAL_BIT = 1;
    // status fields
    localparam int STAT_PRESC_LSB = 0;
    localparam int STAT_CNT_LSB = 12;
    localparam int STAT_DISABLED_BIT = 18;
    localparam int STAT_LOCK_BIT = 19;
    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // reset sequencer, gray coded from IDLE through HOLD to DONE; DONE back to IDLE changes both bits
    typedef enum logic [1:0] {
        WDT_SEQ_IDLE = 2'b00,
        WDT_SEQ_HOLD = 2'b01,
        WDT_SEQ_DONE = 2'b11
    } wdt_seq_t;
endpackage

// ===== rtl/wdt_pin_sync.sv
// three-stage synchroniser for a pin level, accepted once stages two and three agree
`timescale 1ns/1ns
module wdt_pin_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    wire logic agree = (s2_reg == s3_reg);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= RESET_VALUE;
            s2_reg <= RESET_VALUE;
            s3_reg <= RESET_VALUE;
            level_reg <= RESET_VALUE;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (agree) begin
                level_reg <= s3_reg;
            end
        end
    end

    assign level = level_reg;
endmodule // wdt_pin_sync

// ===== verification/wdt_watchdog_chk.sv
// assertions on the watchdog block ports
`timescale 1ns/1ns
module wdt_watchdog_chk #(
    parameter int ADDR_W = 18
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic [1:0] hresp,
    input wire logic [7:0] reset_vector_low,
    input wire logic internal_reset,
    input wire logic stop_exec,
    input wire logic stop_mode,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_n,
    input wire logic watchdog_reset_req
);
    localparam logic [ADDR_W-1:0] SVC_A = ADDR_W'({wdt_pkg::SERVICE_IDX, 2'b00});
    logic [5:0] hold_cnt;
    // cycles the reset request has been high so far
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hold_cnt <= 6'h00;
        else
            hold_cnt <= watchdog_reset_req ? hold_cnt + 6'h01 : 6'h00;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    oe_req_tie_a:
        assert property (reset_pin_oe_n != watchdog_reset_req) else $error("enable and request differ");
    pin_low_a:
        assert property (!reset_pin_oe_n |-> !reset_pin_out) else $error("reset pin driven high");
    hold_len_a:
        assert property ($fell(watchdog_reset_req) |-> hold_cnt == 6'h20) else $error("hold not 32");
    hold_max_a:
        assert property (watchdog_reset_req |-> hold_cnt < 6'h20) else $error("hold too long");
    bus_okay_a:
        assert property (hreadyout && hresp == wdt_pkg::HRESP_OKAY) else $error("bus not okay");
    vector_read_a:
        assert property (hsel && hready && htrans == wdt_pkg::HTRANS_NONSEQ && !hwrite
            && hsize == wdt_pkg::HSIZE_WORD && haddr == SVC_A
            |=> hrdata == {24'h00_0000, $past(reset_vector_low)}) else $error("bad vector byte");
    int_reset_clear_a:
        assert property (internal_reset ##1 !stop_exec |=> !$rose(watchdog_reset_req))
            else $error("reset right after internal reset");
    stop_freeze_a:
        assert property (stop_mode && !stop_exec |=> !$rose(watchdog_reset_req))
            else $error("timeout in stop mode");
endmodule // wdt_watchdog_chk

bind wdt_watchdog wdt_watchdog_chk #(.ADDR_W(ADDR_W)) u_wdt_watchdog_chk (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hrdata, .hreadyout, .hresp,
    .reset_vector_low, .internal_reset, .stop_exec, .stop_mode, .reset_pin_out,
    .reset_pin_oe_n, .watchdog_reset_req);

// ===== verification/wdt_core_model.sv
// core and reset line model on the far side of the watchdog
`timescale 1ns/1ns
module wdt_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_n,
    output logic rst_pin,
    output logic vector_fetch,
    output logic pulse_done,
    output logic [7:0] pulse_len
);
    logic [7:0] low_cnt;
    // line has a pull-up, low only while the watchdog drives it
    assign rst_pin = reset_pin_oe_n ? 1'b1 : reset_pin_out;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt <= 8'h00;
            pulse_done <= 1'b0;
            pulse_len <= 8'h00;
            vector_fetch <= 1'b0;
        end else begin
            low_cnt <= rst_pin ? 8'h00 : low_cnt + 8'h01;
            pulse_done <= rst_pin && low_cnt != 8'h00;
            pulse_len <= low_cnt;
            // core fetches the reset vector once the line is released
            vector_fetch <= rst_pin && low_cnt != 8'h00;
        end
    end
endmodule // wdt_core_model

// ===== verification/test_watchdog_timeout_reset.sv
// self-checking bench for the watchdog block
`timescale 1ns/1ns
module test_watchdog_timeout_reset;
    localparam logic [17:0] A_SVC = 18'({wdt_pkg::SERVICE_IDX, 2'b00});
    localparam logic [17:0] A_CFG = 18'({wdt_pkg::CFG_IDX, 2'b00});
    localparam logic [17:0] A_CAU = 18'({wdt_pkg::CAUSE_IDX, 2'b00});
    localparam logic [17:0] A_STA = 18'({wdt_pkg::STATUS_IDX, 2'b00});
    localparam logic [17:0] A_BAD = 18'h0_000c;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [17:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic [31:0] hwdata = '0, res_val = '0, hrdata, seen;
    logic hreadyout, oe_n, pin_out, req, rst_pin, vfetch, p_done;
    logic [1:0] hresp;
    logic [7:0] vec_low = 8'h00, p_len;
    logic int_rst = 0, stop_exec = 0, stop_mode = 0, wait_mode = 0, mon = 0;
    logic brk = 0, tv_irq = 0, tv_rst = 0;
    logic rd_take = 0, res_valid = 0;
    logic [31:0] exp_q[$], msk_q[$];
    string nam_q[$];
    int miscompares = 0, compares = 0, seed = 32'h7253, k;
    initial begin
        forever #10 hclk = ~hclk;
    end
    wdt_watchdog u_wdt_watchdog (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(wdt_pkg::HSIZE_WORD), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .reset_vector_low(vec_low), .internal_reset(int_rst), .vector_fetch(vfetch),
        .stop_exec(stop_exec), .stop_mode(stop_mode), .wait_mode(wait_mode),
        .monitor_mode(mon), .break_active(brk), .irq_test_high_voltage(tv_irq),
        .rst_test_high_voltage(tv_rst), .reset_pin_out(pin_out), .reset_pin_oe_n(oe_n),
        .watchdog_reset_req(req));
    wdt_core_model u_wdt_core_model (.hclk(hclk), .hresetn(hresetn), .reset_pin_out(pin_out),
        .reset_pin_oe_n(oe_n), .rst_pin(rst_pin), .vector_fetch(vfetch), .pulse_done(p_done),
        .pulse_len(p_len));
    task automatic check(string nm, logic [31:0] s, logic [31:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic report_and_stop();
        // an expected result that never showed up counts as a mismatch
        if (exp_q.size() != 0)
            miscompares++;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic note(string nm, logic [31:0] e, logic [31:0] m);
        nam_q.push_back(nm);
        exp_q.push_back(e);
        msk_q.push_back(m);
    endtask
    task automatic wait_rdy();
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                return;
        end
        miscompares++;
        report_and_stop();
    endtask
    // one single word transfer; on reads d is the expected value under mask m
    task automatic bus(logic wr, logic [17:0] a, logic [31:0] d, logic [31:0] m, string nm);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= wdt_pkg::HTRANS_NONSEQ;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rd_take <= !wr;
        if (!wr)
            note(nm, d, m);
        wait_rdy();
        rd_take <= 1'b0;
    endtask
    task automatic res(string nm, logic [31:0] v, logic [31:0] e);
        note(nm, e, 32'hffff_ffff);
        res_val <= v;
        res_valid <= 1'b1;
        @(posedge hclk);
        res_valid <= 1'b0;
    endtask
    task automatic quiet(int c, string nm);
        int lows;
        lows = 0;
        repeat (c) begin
            @(negedge hclk);
            if (oe_n !== 1'b1)
                lows++;
        end
        res(nm, 32'(lows), 32'h0000_0000);
    endtask
    task automatic period(string nm);
        for (k = 1; k < 9000 && oe_n !== 1'b0; k++)
            @(negedge hclk);
        res(nm, 32'(k >= 8160 && k <= 8178), 32'h0000_0001);
        note("pulse width", 32'h0000_0020, 32'h0000_00ff);
        repeat (60) @(posedge hclk);
    endtask
    assign seen = rd_take ? hrdata : (p_done ? {24'h00_0000, p_len} : res_val);
    always @(posedge hclk) begin
        if ((rd_take || p_done || res_valid) && exp_q.size() > 0)
            check(nam_q.pop_front(), seen & msk_q.pop_front(), exp_q.pop_front());
    end
    initial begin
        repeat (95000) @(posedge hclk);
        miscompares++;
        report_and_stop();
    end
    initial begin
        vec_low <= 8'($random(seed));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, A_CFG, 32'h0000_0000, 32'hffff_ffff, "cfg reset");
        bus(0, A_CAU, 32'h0000_0000, 32'hffff_ffff, "cause reset");
        bus(0, A_SVC, {24'h00_0000, vec_low}, 32'hffff_ffff, "vector byte");
        bus(0, A_BAD, 32'h0000_0000, 32'hffff_ffff, "unmapped");
        quiet(9000, "long rate quiet");
        bus(1, A_CFG, 32'h0000_0006, 32'h0, "");
        bus(1, A_CFG, 32'h0000_0001, 32'h0, "");
        bus(0, A_CFG, 32'h0000_0006, 32'hffff_ffff, "cfg once");
        bus(1, A_SVC, $random(seed), 32'h0, "");
        period("short period");
        bus(0, A_CAU, 32'h0000_0001, 32'hffff_ffff, "cause set");
        bus(1, A_CAU, 32'h0000_0001, 32'h0, "");
        bus(0, A_CAU, 32'h0000_0000, 32'hffff_ffff, "cause clear");
        bus(0, A_CFG, 32'h0000_0000, 32'hffff_ffff, "cfg after reset");
        bus(1, A_CFG, 32'h0000_0006, 32'h0, "");
        for (int i = 0; i < 3; i++) begin
            repeat (4000) @(posedge hclk);
            bus(1, A_SVC, $random(seed), 32'h0, "");
        end
        bus(0, A_CAU, 32'h0000_0000, 32'hffff_ffff, "serviced");
        int_rst <= 1'b1;
        @(posedge hclk);
        int_rst <= 1'b0;
        bus(1, A_CFG, 32'h0000_0007, 32'h0, "");
        quiet(9000, "disabled quiet");
        bus(0, A_STA, 32'h000c_0000, 32'h000f_ffff, "chain held");
        int_rst <= 1'b1;
        @(posedge hclk);
        int_rst <= 1'b0;
        bus(1, A_CFG, 32'h0000_0002, 32'h0, "");
        stop_exec <= 1'b1;
        note("illegal pulse", 32'h0000_0020, 32'h0000_00ff);
        @(posedge hclk);
        stop_exec <= 1'b0;
        repeat (60) @(posedge hclk);
        bus(0, A_CAU, 32'h0000_0002, 32'h0000_0002, "illegal cause");
        bus(1, A_CFG, 32'h0000_0006, 32'h0, "");
        stop_exec <= 1'b1;
        stop_mode <= 1'b1;
        @(posedge hclk);
        stop_exec <= 1'b0;
        quiet(9000, "stop quiet");
        stop_mode <= 1'b0;
        wait_mode <= 1'b1;
        period("wait period");
        wait_mode <= 1'b0;
        bus(1, A_CFG, 32'h0000_0002, 32'h0, "");
        brk <= 1'b1;
        tv_rst <= 1'b1;
        repeat (6) @(posedge hclk);
        bus(0, A_STA, 32'h0004_0000, 32'h0004_0000, "break disable");
        brk <= 1'b0;
        tv_irq <= 1'b1;
        repeat (6) @(posedge hclk);
        bus(0, A_STA, 32'h0000_0000, 32'h0004_0000, "voltage alone");
        mon <= 1'b1;
        repeat (2) @(posedge hclk);
        tv_irq <= 1'b0;
        repeat (6) @(posedge hclk);
        bus(0, A_STA, 32'h0004_0000, 32'h0004_0000, "monitor reset pin");
        tv_rst <= 1'b0;
        repeat (6) @(posedge hclk);
        bus(0, A_STA, 32'h0000_0000, 32'h0004_0000, "monitor released");
        mon <= 1'b0;
        @(posedge hclk);
        mon <= 1'b1;
        repeat (6) @(posedge hclk);
        mon <= 1'b0;
        bus(0, A_STA, 32'h0004_0000, 32'h0004_0000, "blank disable");
        quiet(9000, "monitor quiet");
        // let the checking process take the last result first
        repeat (2) @(posedge hclk);
        report_and_stop();
    end
endmodule // test_watchdog_timeout_reset
